/* File: rtl/mmb_pkg.sv */
package mmb_pkg;

  // ****************************************************************
  // Special-function-register offsets.
  // ****************************************************************
  localparam logic [7:0] ADDR_PTR0_LO  = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HI  = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LO  = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HI  = 8'h85;
  localparam logic [7:0] ADDR_PTR_SEL  = 8'h92;
  localparam logic [7:0] ADDR_PAGE     = 8'h93;
  localparam logic [7:0] ADDR_CODE_MAP = 8'h9F;
  localparam logic [7:0] ADDR_ARB_CTL  = 8'hC7;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int         SRAM_MAP_BIT   = 3;
  localparam int         BANK_LSB       = 0;
  localparam int         BANK_W         = 3;
  localparam int         PTR_SEL_BIT    = 0;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [2:0] RST_XBANK      = 3'h0;
  localparam logic [2:0] RST_CODE_MAP   = 3'h1;
  localparam logic [7:0] ARB_CTL_MASK   = 8'h0F;
  localparam logic [7:0] CODE_MAP_MASK  = 8'h07;
  localparam logic [7:0] PTR_SEL_MASK   = 8'h01;

  // ****************************************************************
  // Memory layout.
  // ****************************************************************
  localparam logic [15:0] UPPER_BASE     = 16'h8000;
  localparam logic [14:0] SRAM_SIZE      = 15'h2000;
  localparam int          PHYS_W         = 18;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [2:0] {
    MMB_FLASH_32K  = 3'b000,
    MMB_FLASH_64K  = 3'b001,
    MMB_FLASH_96K  = 3'b010,
    MMB_FLASH_128K = 3'b011,
    MMB_FLASH_256K = 3'b100
  } mmb_flash_t;

  typedef enum logic [1:0] {
    MMB_MODE_DIRECT  = 2'b00,
    MMB_MODE_PAGED   = 2'b01,
    MMB_MODE_POINTER = 2'b10
  } mmb_mode_t;

  typedef enum logic [1:0] {
    MMB_ARB_IDLE = 2'b00,
    MMB_ARB_CPU  = 2'b01,
    MMB_ARB_DMA  = 2'b10
  } mmb_arb_t;

  // Highest bank number accepted for a flash size.
  function automatic logic [2:0] mmb_max_bank(input mmb_flash_t sz);
    case (sz)
      MMB_FLASH_64K:  mmb_max_bank = 3'h1;
      MMB_FLASH_96K:  mmb_max_bank = 3'h2;
      MMB_FLASH_128K: mmb_max_bank = 3'h3;
      MMB_FLASH_256K: mmb_max_bank = 3'h7;
      default:        mmb_max_bank = 3'h0;
    endcase
  endfunction

endpackage

/* File: rtl/mmb_addr_map.sv */
`timescale 1ns/1ps
module mmb_addr_map (
  // Logical access.
  input  wire logic                       is_code,
  input  wire logic [15:0]                addr,
  // Bank state.
  input  wire logic                       sram_code_map_enable,
  input  wire logic [2:0]                 xdata_flash_bank_select,
  input  wire logic [2:0]                 code_bank_map,
  // Physical target.
  output logic                            to_flash,
  output logic [mmb_pkg::PHYS_W-1:0]      phys_addr
);
  import mmb_pkg::*;

  // ****************************************************************
  // Logical to physical decode.
  // ****************************************************************
  always_comb begin
    to_flash  = 1'b0;
    phys_addr = {3'h0, addr[14:0]};
    if (addr < UPPER_BASE) begin
      to_flash = is_code;
    end else if (is_code) begin
      if (sram_code_map_enable && (addr[14:0] < SRAM_SIZE)) begin
        to_flash = 1'b0;
      end else begin
        to_flash  = 1'b1;
        phys_addr = {code_bank_map, addr[14:0]};
      end
    end else begin
      to_flash  = 1'b1;
      phys_addr = {xdata_flash_bank_select, addr[14:0]};
    end
  end

endmodule

/* File: rtl/mmb_arbiter.sv */
`timescale 1ns/1ps
module mmb_arbiter (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Requests.
  input  wire logic cpu_req,
  input  wire logic cpu_flash,
  input  wire logic dma_req,
  input  wire logic dma_flash,
  // Grants.
  output logic      grant_cpu,
  output logic      grant_dma
);
  import mmb_pkg::*;

  mmb_arb_t last_r;
  logic     clash;

  // ****************************************************************
  // Grant with alternating priority on a clash.
  // ****************************************************************
  assign clash = cpu_req && dma_req && (cpu_flash == dma_flash);

  always_comb begin
    grant_cpu = cpu_req;
    grant_dma = dma_req;
    if (clash) begin
      grant_cpu = (last_r == MMB_ARB_DMA);
      grant_dma = (last_r != MMB_ARB_DMA);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      last_r <= MMB_ARB_IDLE;
    end else if (clash) begin
      last_r <= grant_cpu ? MMB_ARB_CPU : MMB_ARB_DMA;
    end
  end

endmodule

/* File: rtl/mmb_memory_map.sv */
// Notes on behaviour
// - Paged moves use page high, index low.
// - Conflicting CPU and DMA accesses stall one.
// - Map enable puts SRAM into upper code.
// - Data bank field picks upper data flash bank.
// - Out-of-range data bank writes are ignored.
// - Code bank field picks upper code bank; reset 1.
// - Out-of-range code bank writes ignored; smallest none.
// - Select bit zero chooses active data pointer.
// - Two 16-bit pointers, byte registers reset zero.
// - Page register is 8-bit read-write, reset zero.
`timescale 1ns/1ps
module mmb_memory_map #(
  parameter mmb_pkg::mmb_flash_t FLASH_SIZE = mmb_pkg::MMB_FLASH_256K
) (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Special-function-register port.
  input  wire logic [7:0]                    sfr_addr,
  input  wire logic                          sfr_wr,
  input  wire logic [7:0]                    sfr_wdata,
  input  wire logic                          sfr_rd,
  output logic [7:0]                         sfr_rdata,
  output logic                               sfr_hit,
  // CPU access.
  input  wire logic                          cpu_req,
  input  wire logic                          cpu_is_code,
  input  wire mmb_pkg::mmb_mode_t            cpu_mode,
  input  wire logic [15:0]                   cpu_addr,
  input  wire logic [7:0]                    indirect_index_register,
  output logic                               cpu_stall,
  // DMA access.
  input  wire logic                          dma_req,
  input  wire logic [15:0]                   dma_addr,
  output logic                               dma_stall,
  // Physical memory.
  output logic                               mem_req,
  output logic                               mem_to_flash,
  output logic [mmb_pkg::PHYS_W-1:0]         mem_addr,
  output logic                               mem_from_dma,
  // Pointer state.
  output logic [15:0]                        active_pointer
);
  import mmb_pkg::*;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0]        pointer_zero_low_r;
  logic [7:0]        pointer_zero_high_r;
  logic [7:0]        pointer_one_low_r;
  logic [7:0]        pointer_one_high_r;
  logic              pointer_select_r;
  logic [7:0]        memory_page_select_r;
  logic [2:0]        code_bank_map_r;
  logic              sram_code_map_enable_r;
  logic [2:0]        xdata_flash_bank_select_r;
  logic [2:0]        max_bank;
  logic [2:0]        new_bank;
  logic              bank_ok;
  logic              map_ok;

  // ****************************************************************
  // Bank write validation.
  // ****************************************************************
  assign max_bank = mmb_max_bank(FLASH_SIZE);
  assign new_bank = sfr_wdata[BANK_LSB +: BANK_W];
  assign bank_ok  = (new_bank <= max_bank);
  assign map_ok   = bank_ok && (FLASH_SIZE != MMB_FLASH_32K);

  // ****************************************************************
  // Register write decode.
  // ****************************************************************
  function automatic logic wr_at(input logic       we,
                                 input logic [7:0] a,
                                 input logic [7:0] offset);
    wr_at = we && (a == offset);
  endfunction

  // ****************************************************************
  // Data pointers.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pointer_zero_low_r <= RST_BYTE;
    end else if (wr_at(sfr_wr, sfr_addr, ADDR_PTR0_LO)) begin
      pointer_zero_low_r <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pointer_zero_high_r <= RST_BYTE;
    end else if (wr_at(sfr_wr, sfr_addr, ADDR_PTR0_HI)) begin
      pointer_zero_high_r <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pointer_one_low_r <= RST_BYTE;
    end else if (wr_at(sfr_wr, sfr_addr, ADDR_PTR1_LO)) begin
      pointer_one_low_r <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pointer_one_high_r <= RST_BYTE;
    end else if (wr_at(sfr_wr, sfr_addr, ADDR_PTR1_HI)) begin
      pointer_one_high_r <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pointer_select_r <= 1'b0;
    end else if (sfr_wr && (sfr_addr == ADDR_PTR_SEL)) begin
      pointer_select_r <= sfr_wdata[PTR_SEL_BIT];
    end
  end

  // ****************************************************************
  // Memory page.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      memory_page_select_r <= RST_BYTE;
    end else if (sfr_wr && (sfr_addr == ADDR_PAGE)) begin
      memory_page_select_r <= sfr_wdata;
    end
  end

  // ****************************************************************
  // Arbiter control and code bank map.
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      sram_code_map_enable_r <= RST_BYTE[SRAM_MAP_BIT];
    end else if (wr_at(sfr_wr, sfr_addr, ADDR_ARB_CTL)) begin
      sram_code_map_enable_r <= sfr_wdata[SRAM_MAP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      xdata_flash_bank_select_r <= RST_XBANK;
    end else if (wr_at(sfr_wr, sfr_addr, ADDR_ARB_CTL) && bank_ok) begin
      xdata_flash_bank_select_r <= new_bank;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      code_bank_map_r <= RST_CODE_MAP;
    end else if (sfr_wr && (sfr_addr == ADDR_CODE_MAP) && map_ok) begin
      code_bank_map_r <= new_bank;
    end
  end

  // ****************************************************************
  // Register read-back.
  // ****************************************************************
  logic [7:0] rd_val;
  logic       rd_hit;

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (sfr_addr)
      ADDR_PTR0_LO:  rd_val = pointer_zero_low_r;
      ADDR_PTR0_HI:  rd_val = pointer_zero_high_r;
      ADDR_PTR1_LO:  rd_val = pointer_one_low_r;
      ADDR_PTR1_HI:  rd_val = pointer_one_high_r;
      ADDR_PTR_SEL:  rd_val = {7'h00, pointer_select_r} & PTR_SEL_MASK;
      ADDR_PAGE:     rd_val = memory_page_select_r;
      ADDR_CODE_MAP: rd_val = {5'h00, code_bank_map_r} & CODE_MAP_MASK;
      ADDR_ARB_CTL:  rd_val = {4'h0, sram_code_map_enable_r,
                               xdata_flash_bank_select_r} & ARB_CTL_MASK;
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= sfr_rd ? rd_val : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= sfr_rd && rd_hit;
    end
  end

  // ****************************************************************
  // Active pointer and CPU address formation.
  // ****************************************************************
  logic [15:0] ptr_sel_val;
  logic [15:0] cpu_log_addr;

  assign ptr_sel_val = pointer_select_r ? {pointer_one_high_r, pointer_one_low_r}
                                        : {pointer_zero_high_r, pointer_zero_low_r};

  always_comb begin
    case (cpu_mode)
      MMB_MODE_PAGED:   cpu_log_addr = {memory_page_select_r, indirect_index_register};
      MMB_MODE_POINTER: cpu_log_addr = ptr_sel_val;
      default:          cpu_log_addr = cpu_addr;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_pointer <= 16'h0000;
    end else begin
      active_pointer <= ptr_sel_val;
    end
  end

  // ****************************************************************
  // Physical decode for both masters.
  // ****************************************************************
  logic              cpu_flash;
  logic              dma_flash;
  logic [PHYS_W-1:0] cpu_phys;
  logic [PHYS_W-1:0] dma_phys;
  logic              grant_cpu;
  logic              grant_dma;

  mmb_addr_map u_cpu_map (
    .is_code                 (cpu_is_code),
    .addr                    (cpu_log_addr),
    .sram_code_map_enable    (sram_code_map_enable_r),
    .xdata_flash_bank_select (xdata_flash_bank_select_r),
    .code_bank_map           (code_bank_map_r),
    .to_flash                (cpu_flash),
    .phys_addr               (cpu_phys)
  );

  mmb_addr_map u_dma_map (
    .is_code                 (1'b0),
    .addr                    (dma_addr),
    .sram_code_map_enable    (sram_code_map_enable_r),
    .xdata_flash_bank_select (xdata_flash_bank_select_r),
    .code_bank_map           (code_bank_map_r),
    .to_flash                (dma_flash),
    .phys_addr               (dma_phys)
  );

  // ****************************************************************
  // Arbitration and physical request.
  // ****************************************************************
  mmb_arbiter u_arb (
    .clk       (clk),
    .rst       (rst),
    .cpu_req   (cpu_req),
    .cpu_flash (cpu_flash),
    .dma_req   (dma_req),
    .dma_flash (dma_flash),
    .grant_cpu (grant_cpu),
    .grant_dma (grant_dma)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_stall <= 1'b0;
    end else begin
      cpu_stall <= cpu_req && !grant_cpu;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dma_stall <= 1'b0;
    end else begin
      dma_stall <= dma_req && !grant_dma;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_req      <= 1'b0;
      mem_from_dma <= 1'b0;
    end else begin
      mem_req      <= grant_cpu || grant_dma;
      mem_from_dma <= grant_dma && !grant_cpu;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_to_flash <= 1'b0;
      mem_addr     <= '0;
    end else if (grant_cpu) begin
      mem_to_flash <= cpu_flash;
      mem_addr     <= cpu_phys;
    end else if (grant_dma) begin
      mem_to_flash <= dma_flash;
      mem_addr     <= dma_phys;
    end
  end

endmodule

/* File: tb/mmb_memory_map_sva.sv */
`timescale 1ns/1ps
module mmb_memory_map_sva (
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rst,
  // Register port.
  input wire logic [7:0]         sfr_addr,
  input wire logic               sfr_rd,
  input wire logic [7:0]         sfr_rdata,
  input wire logic               sfr_hit,
  // Masters.
  input wire logic               cpu_req,
  input wire logic               cpu_is_code,
  input wire mmb_pkg::mmb_mode_t cpu_mode,
  input wire logic [15:0]        cpu_addr,
  input wire logic               cpu_stall,
  input wire logic               dma_req,
  input wire logic [15:0]        dma_addr,
  input wire logic               dma_stall,
  // Memory side.
  input wire logic               mem_req,
  input wire logic               mem_from_dma
);
  import mmb_pkg::*;
  // ********
  // Checks.
  // ********
  logic clash;
  assign clash = cpu_req && dma_req && cpu_mode == MMB_MODE_DIRECT && !cpu_is_code
                 && !cpu_addr[15] && !dma_addr[15];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  page_hit_a: assert property (
    sfr_rd && sfr_addr == ADDR_PAGE |=> sfr_hit) else $error("page read not acknowledged");
  sel_zero_a: assert property (
    sfr_rd && sfr_addr == ADDR_PTR_SEL |=> sfr_rdata[7:1] == 7'h00) else $error("select bits");
  map_zero_a: assert property (
    sfr_rd && sfr_addr == ADDR_CODE_MAP |=> sfr_rdata[7:3] == 5'h00) else $error("map bits");
  arb_zero_a: assert property (
    sfr_rd && sfr_addr == ADDR_ARB_CTL |=> sfr_rdata[7:4] == 4'h0) else $error("arbiter bits");
  clash_stall_a: assert property (
    clash |=> mem_req && cpu_stall != dma_stall && mem_from_dma == cpu_stall)
    else $error("clash not resolved");
  cpu_grant_a: assert property (
    cpu_req && !dma_req |=> mem_req && !cpu_stall && !mem_from_dma) else $error("cpu not served");
  dma_grant_a: assert property (
    !cpu_req && dma_req |=> mem_req && mem_from_dma && !dma_stall) else $error("dma not served");
  one_stall_a: assert property (cpu_stall |-> !dma_stall)
    else $error("both masters stalled");
  cover property (clash);
  cover property (clash ##1 cpu_stall);
  cover property (clash ##1 dma_stall);
endmodule

bind mmb_memory_map mmb_memory_map_sva u_mmb_memory_map_sva (.*);

/* File: tb/mmb_dma_master.sv */
`timescale 1ns/1ps
module mmb_dma_master (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Job from the bench.
  input  wire logic        start,
  input  wire logic [15:0] start_addr,
  output logic             done,
  // Request to the block.
  input  wire logic        dma_stall,
  output logic             dma_req,
  output logic [15:0]      dma_addr
);
  // ********
  // One-cycle request, retried after a stall; address parked inverted when idle.
  // ********
  logic wait_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_req  <= 1'h0;
      dma_addr <= 16'hFFFF;
      wait_r   <= 1'h0;
      done     <= 1'h0;
    end else if (start) begin
      dma_req  <= 1'h1;
      dma_addr <= start_addr;
      done     <= 1'h0;
    end else if (dma_req) begin
      dma_req  <= 1'h0;
      dma_addr <= ~dma_addr;
      wait_r   <= 1'h1;
    end else if (wait_r) begin
      dma_req  <= dma_stall;
      dma_addr <= dma_stall ? ~dma_addr : dma_addr;
      wait_r   <= 1'h0;
      done     <= !dma_stall;
    end
  end
endmodule

/* File: tb/tb_mmb_memory_map.sv */
`timescale 1ns/1ps
module tb_mmb_memory_map;
  import mmb_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} mmb_row_t;
  logic              clk, rst, sfr_wr, sfr_rd, sfr_hit, cpu_req, cpu_is_code, cpu_stall;
  logic              dma_req, dma_stall, mem_req, mem_to_flash, mem_from_dma, start, done, h;
  logic [7:0]        sfr_addr, sfr_wdata, sfr_rdata, rdata_s, indirect_index_register;
  logic [7:0]        v, vs, vm, ex, rdata_m;
  logic [15:0]       cpu_addr, dma_addr, start_addr, active_pointer;
  logic [PHYS_W-1:0] mem_addr;
  mmb_mode_t         cpu_mode;
  int                fail_count, n_tests, k;
  mmb_row_t          rows [9] = '{'{8'h93, 8'h5A, 8'h5A}, '{8'h82, 8'h11, 8'h11},
    '{8'h83, 8'h22, 8'h22}, '{8'h84, 8'h33, 8'h33}, '{8'h85, 8'h44, 8'h44},
    '{8'h92, 8'hFF, 8'h01}, '{8'h9F, 8'hFD, 8'h05}, '{8'hC7, 8'hFE, 8'h0E},
    '{8'h90, 8'hAA, 8'h00}};
  logic [7:0]        regs [8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'h93, 8'h9F, 8'hC7};

  mmb_memory_map u_mmb_memory_map (.*);
  mmb_memory_map #(.FLASH_SIZE(MMB_FLASH_32K)) u_mmb_memory_map_small (.*,
    .sfr_rdata(rdata_s), .sfr_hit(), .cpu_stall(), .dma_stall(), .mem_req(),
    .mem_to_flash(), .mem_addr(), .mem_from_dma(), .active_pointer());
  mmb_memory_map #(.FLASH_SIZE(MMB_FLASH_96K)) u_mmb_memory_map_mid (.*,
    .sfr_rdata(rdata_m), .sfr_hit(), .cpu_stall(), .dma_stall(), .mem_req(),
    .mem_to_flash(), .mem_addr(), .mem_from_dma(), .active_pointer());
  mmb_dma_master u_mmb_dma_master (.*);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [18:0] e, input logic [18:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    @(posedge clk);
    #1 sfr_wr = 1'h0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'h1;
    @(posedge clk);
    #1 sfr_rd = 1'h0;
    v = sfr_rdata;
    vs = rdata_s;
    vm = rdata_m;
    h = sfr_hit;
    @(posedge clk);
    #1;
  endtask

  task automatic acc(input mmb_mode_t m, input logic c, input logic [15:0] a,
                     input logic [7:0] i, input logic [18:0] e);
    cpu_mode = m;
    cpu_is_code = c;
    cpu_addr = a;
    indirect_index_register = i;
    cpu_req = 1'h1;
    @(posedge clk);
    #1 cpu_req = 1'h0;
    chk("memory target", e, {mem_to_flash, mem_addr});
    @(posedge clk);
    #1;
  endtask

  task automatic clash(input logic dma_wins);
    start_addr = 16'h0200;
    start = 1'h1;
    @(posedge clk);
    #1 start = 1'h0;
    acc(MMB_MODE_DIRECT, 1'h0, 16'h0100, 8'h00, dma_wins ? 19'h00200 : 19'h00100);
    for (k = 0; k < 10 && done !== 1'h1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("dma done", 1'h1, done);
    if (done !== 1'h1) test_done();
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    {sfr_wr, sfr_rd, cpu_req, cpu_is_code, start} = 5'h00;
    {sfr_addr, sfr_wdata, indirect_index_register} = 24'h000000;
    {cpu_addr, start_addr} = 32'h00000000;
    cpu_mode = MMB_MODE_DIRECT;
    fail_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    #1 rst = 1'h0;
    for (k = 0; k < 9; k++) begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a);
      chk("register readback", {rows[k].e, rows[k].a != 8'h90}, {v, h});
    end
    $display("test register rows done");
    rst = 1'h1;
    @(posedge clk);
    #1 rst = 1'h0;
    for (k = 0; k < 8; k++) begin
      ex = (regs[k] == ADDR_CODE_MAP) ? {5'h00, RST_CODE_MAP} : RST_BYTE;
      rd(regs[k]);
      chk("reset value", {ex, ex}, {v, vs});
    end
    $display("test reset done");
    wr(ADDR_ARB_CTL, 8'h01);
    rd(ADDR_ARB_CTL);
    chk("data bank", 16'h0100, {v, vs});
    wr(ADDR_CODE_MAP, 8'h00);
    rd(ADDR_CODE_MAP);
    chk("code bank", 16'h0001, {v, vs});
    wr(ADDR_ARB_CTL, 8'h03);
    rd(ADDR_ARB_CTL);
    chk("data bank limit", 16'h0301, {v, vm});
    wr(ADDR_CODE_MAP, 8'h02);
    rd(ADDR_CODE_MAP);
    chk("code bank limit", 16'h0202, {v, vm});
    wr(ADDR_CODE_MAP, 8'h03);
    rd(ADDR_CODE_MAP);
    chk("code bank limit", 16'h0302, {v, vm});
    $display("test bank range done");
    wr(ADDR_PAGE, 8'h80);
    wr(ADDR_ARB_CTL, 8'h05);
    acc(MMB_MODE_PAGED, 1'h0, 16'h0000, 8'h10, {1'h1, 3'h5, 15'h0010});
    wr(ADDR_PAGE, 8'h12);
    acc(MMB_MODE_PAGED, 1'h0, 16'h0000, 8'h34, 19'h01234);
    wr(ADDR_CODE_MAP, 8'h03);
    acc(MMB_MODE_DIRECT, 1'h1, 16'h8123, 8'h00, {1'h1, 3'h3, 15'h0123});
    wr(ADDR_ARB_CTL, 8'h0D);
    acc(MMB_MODE_DIRECT, 1'h1, 16'h8123, 8'h00, 19'h00123);
    acc(MMB_MODE_DIRECT, 1'h1, 16'hA123, 8'h00, {1'h1, 3'h3, 15'h2123});
    acc(MMB_MODE_DIRECT, 1'h0, 16'h9000, 8'h00, {1'h1, 3'h5, 15'h1000});
    $display("test mapping done");
    wr(ADDR_PTR1_LO, 8'hCD);
    wr(ADDR_PTR1_HI, 8'h1B);
    wr(ADDR_PTR_SEL, 8'h01);
    acc(MMB_MODE_POINTER, 1'h0, 16'h0000, 8'h00, 19'h01BCD);
    chk("active_pointer", 16'h1BCD, active_pointer);
    wr(ADDR_PTR_SEL, 8'h00);
    chk("active_pointer", 16'h0000, active_pointer);
    $display("test pointers done");
    clash(1'h1);
    clash(1'h0);
    $display("test arbitration done");
    test_done();
  end
endmodule
